// ===== include/psp_defs.vh
// constants for the parallel slave port: register indexes, field positions,
// reset values and the instruction-phase encoding
`ifndef PSP_DEFS_VH
`define PSP_DEFS_VH

// register indexes; byte address is four times the index
`define PSP_IDX_DATA_PORT_LATCH        8'h08
`define PSP_IDX_STROBE_PORT_PINS       8'h09
`define PSP_IDX_PERIPHERAL_IRQ_FLAGS   8'h0C
`define PSP_IDX_DATA_PORT_DIRECTION    8'h88
`define PSP_IDX_SLAVE_PORT_CONTROL     8'h89
`define PSP_IDX_PERIPHERAL_IRQ_ENABLES 8'h8C
`define PSP_IDX_ANALOG_PIN_CONFIG      8'h9F

// slave_port_control fields
`define PSP_BIT_IN_FULL      7
`define PSP_BIT_OUT_FULL     6
`define PSP_BIT_IN_OVERFLOW  5
`define PSP_BIT_MODE_SELECT  4
`define PSP_DIR_MSB          2

// strobe pin positions within the control port
`define PSP_PIN_READ   0
`define PSP_PIN_WRITE  1
`define PSP_PIN_SELECT 2

// slave port irq flag / enable position
`define PSP_BIT_IRQ 7

// analog_pin_config: bit 7 and field 3:0 are implemented
`define PSP_ANALOG_CFG_MASK 8'h8F
// field values whose bits 2:1 are both set make the control pins digital
`define PSP_PCFG_DIGITAL    2'h3

// reset values
`define PSP_RST_DIRECTION   8'hFF
`define PSP_RST_STROBE_DIR  3'h7
`define PSP_RST_ZERO8       8'h00
`define PSP_RST_ZERO3       3'h0

// instruction phases: Q1..Q4 as a free running two-bit count
`define PSP_PHASE_Q2 2'h1
`define PSP_PHASE_Q4 2'h3

// end-of-transfer sequencer states, one-hot
`define PSP_SEQ_IDLE   3'h1
`define PSP_SEQ_WAIT2  3'h2
`define PSP_SEQ_WAIT4  3'h4

// AHB-Lite
`define PSP_HTRANS_NONSEQ_BIT 1
`define PSP_HRESP_OKAY        1'h0

`endif

// ===== logic/psp_port.v
// parallel slave port: an 8-bit port that an external processor reads and
// writes with active-low read, write and select strobes, plus its registers.
// assumes one AHB-Lite master, a 50 MHz clk_sys and pin levels resolved by
// the surrounding pad logic from the output enables.
//
// Notes on behaviour
// RL1 - mode select bit turns the data port into the 8-bit slave port
// RL2 - external reads and writes follow the strobes, not the core clock
// RL3 - in slave mode pin 0 reads, pin 1 writes, pin 2 selects, all low active
// RL4 - firmware sets the three control pin directions to input first
// RL5 - firmware configures the strobe pins as digital before slave mode
// RL6 - two 8-bit latches at one address: writes go out, reads come in
// RL7 - slave mode ignores data direction; pins driven only during selected read
// RL8 - select and write low together load pin data into the input latch
// RL9 - end of write sets input full on the Q4 following the next Q2
// RL10 - end of write sets the port irq flag on that same Q4
// RL11 - in slave mode input full clears only on an internal read; writes leave it alone
// RL12 - a write while input full is still set raises overflow
// RL13 - select and read low together drive the output latch onto the pins
// RL14 - start of an external read clears output full at once
// RL15 - end of read sets the port irq flag on the Q4 after the next Q2
// RL16 - output full stays clear until firmware writes the data port again
// RL17 - outside slave mode both full flags are held clear, overflow kept
// RL18 - firmware clears overflow and irq flag; enable gates the request
// RL19 - control direction bits: 1 input, 0 output; reset 1, upper bits 0
// RL20 - strobes pass through synchronisers before edges are detected
// RL21 - an overflowing write still replaces the unread byte
// RL22 - analog-selected control pins read as zero; analog after reset
`timescale 1ns/1ns
`include "psp_defs.vh"

module psp_port (
	// clock and reset
	input  wire        clk_sys,
	input  wire        reset,
	// AHB-Lite slave
	input  wire        hsel,
	input  wire [31:0] haddr,
	input  wire [1:0]  htrans,
	input  wire        hwrite,
	input  wire [2:0]  hsize,
	input  wire [31:0] hwdata,
	input  wire        hready,
	output reg  [31:0] hrdata,
	output reg         hreadyout,
	output reg         hresp,
	// data port pins
	input  wire [7:0]  data_pins_in,
	output reg  [7:0]  data_pins_out,
	output reg  [7:0]  data_pins_oe,
	// control port pins: bit 0 read strobe, bit 1 write strobe, bit 2 select
	input  wire [2:0]  strobe_pins_in,
	output reg  [2:0]  strobe_pins_out,
	output reg  [2:0]  strobe_pins_oe,
	// slave port interrupt request towards the interrupt controller
	output reg         slave_port_irq
);

	// one step of the end-of-transfer sequencer: wait for Q2, then Q4
	function [2:0] seq_step;
		input [2:0] state;
		input       done;
		input       at_q2;
		input       at_q4;
		begin
			case (state)
				`PSP_SEQ_IDLE: begin
					seq_step = done ? `PSP_SEQ_WAIT2 : `PSP_SEQ_IDLE;
				end
				`PSP_SEQ_WAIT2: begin
					seq_step = at_q2 ? `PSP_SEQ_WAIT4 : `PSP_SEQ_WAIT2;
				end
				`PSP_SEQ_WAIT4: begin
					seq_step = at_q4 ? `PSP_SEQ_IDLE : `PSP_SEQ_WAIT4;
				end
				default: begin
					seq_step = `PSP_SEQ_IDLE;
				end
			endcase
		end
	endfunction

	// registers
	reg  [7:0] out_latch;
	reg  [7:0] in_latch;
	reg  [7:0] data_port_direction;
	reg  [2:0] strobe_latch;
	reg  [2:0] strobe_dir;
	reg        slave_mode_select;
	reg        in_buffer_full;
	reg        out_buffer_full;
	reg        in_buffer_overflow;
	reg  [7:0] irq_flags;
	reg  [7:0] irq_enables;
	reg  [7:0] analog_cfg;

	// bus state
	reg        wr_pend;
	reg        rd_pend;
	reg  [7:0] bus_idx;

	// synchronisers and edge state
	reg  [2:0] strobe_meta;
	reg  [2:0] strobe_sync;
	reg  [7:0] data_meta;
	reg  [7:0] data_sync;
	reg        wr_act_q;
	reg        rd_act_q;
	reg  [1:0] phase;
	reg  [2:0] wr_seq;
	reg  [2:0] rd_seq;

	wire       pins_digital;
	wire       at_q2;
	wire       at_q4;
	wire       wr_act;
	wire       rd_act;
	wire       wr_start;
	wire       rd_start;
	wire       wr_fire;
	wire       rd_fire;
	wire       addr_take;
	wire       fw_write;
	wire       fw_read;
	wire [7:0] wdata;
	reg  [7:0] rd_value;
	reg  [7:0] next_data_oe;

	// analog after reset, so the strobes stay idle until firmware selects digital
	assign pins_digital = (analog_cfg[2:1] == `PSP_PCFG_DIGITAL);
	assign at_q2 = (phase == `PSP_PHASE_Q2);
	assign at_q4 = (phase == `PSP_PHASE_Q4);

	assign wr_act = slave_mode_select & pins_digital & ~strobe_sync[`PSP_PIN_SELECT] &
		~strobe_sync[`PSP_PIN_WRITE]; // RL2 RL3 RL8
	assign rd_act = slave_mode_select & pins_digital & ~strobe_sync[`PSP_PIN_SELECT] &
		~strobe_sync[`PSP_PIN_READ]; // RL3 RL13
	assign wr_start = wr_act & ~wr_act_q;
	assign rd_start = rd_act & ~rd_act_q;
	assign wr_fire = wr_seq[2] & at_q4; // RL9
	assign rd_fire = rd_seq[2] & at_q4; // RL15

	assign addr_take = hsel & hready & htrans[`PSP_HTRANS_NONSEQ_BIT];
	assign fw_write = wr_pend;
	assign fw_read = rd_pend;
	assign wdata = hwdata[7:0];

	// read mux for the register in the data phase
	always @* begin
		rd_value = `PSP_RST_ZERO8;
		case (bus_idx)
			`PSP_IDX_DATA_PORT_LATCH: begin
				rd_value = slave_mode_select ? in_latch : data_sync; // RL6
			end
			`PSP_IDX_STROBE_PORT_PINS: begin
				rd_value = pins_digital ? {5'h00, strobe_sync} : `PSP_RST_ZERO8; // RL22
			end
			`PSP_IDX_PERIPHERAL_IRQ_FLAGS: begin
				rd_value = irq_flags;
			end
			`PSP_IDX_DATA_PORT_DIRECTION: begin
				rd_value = data_port_direction;
			end
			`PSP_IDX_SLAVE_PORT_CONTROL: begin
				rd_value = {in_buffer_full, out_buffer_full, in_buffer_overflow,
					slave_mode_select, 1'b0, strobe_dir};
			end
			`PSP_IDX_PERIPHERAL_IRQ_ENABLES: begin
				rd_value = irq_enables;
			end
			`PSP_IDX_ANALOG_PIN_CONFIG: begin
				rd_value = analog_cfg;
			end
			default: begin
				rd_value = `PSP_RST_ZERO8;
			end
		endcase
	end

	// data pin enables: slave mode drives only during a selected read
	always @* begin
		if (slave_mode_select) begin
			next_data_oe = rd_act ? 8'hFF : 8'h00; // RL7 RL13
		end else begin
			next_data_oe = ~data_port_direction;
		end
	end

	// AHB-Lite slave: writes take no wait state, reads take one so that a
	// read straight after a write sees the written value
	always @(posedge clk_sys or posedge reset) begin
		if (reset) begin
			wr_pend <= 1'b0;
			rd_pend <= 1'b0;
			bus_idx <= `PSP_RST_ZERO8;
			hrdata <= 32'h00000000;
			hreadyout <= 1'b1;
			hresp <= `PSP_HRESP_OKAY;
		end else begin
			hresp <= `PSP_HRESP_OKAY;
			wr_pend <= addr_take & hwrite;
			if (rd_pend) begin
				rd_pend <= 1'b0;
				hreadyout <= 1'b1;
				hrdata <= {24'h000000, rd_value};
			end else if (addr_take & ~hwrite) begin
				rd_pend <= 1'b1;
				hreadyout <= 1'b0;
			end
			if (addr_take) begin
				bus_idx <= haddr[9:2];
			end
		end
	end

	// strobe and data synchronisers, phase counter, sequencers
	always @(posedge clk_sys or posedge reset) begin
		if (reset) begin
			strobe_meta <= `PSP_RST_STROBE_DIR;
			strobe_sync <= `PSP_RST_STROBE_DIR;
			data_meta <= `PSP_RST_ZERO8;
			data_sync <= `PSP_RST_ZERO8;
			wr_act_q <= 1'b0;
			rd_act_q <= 1'b0;
			phase <= 2'h0;
			wr_seq <= `PSP_SEQ_IDLE;
			rd_seq <= `PSP_SEQ_IDLE;
		end else begin
			strobe_meta <= strobe_pins_in; // RL20
			strobe_sync <= strobe_meta; // RL20
			data_meta <= data_pins_in;
			data_sync <= data_meta;
			wr_act_q <= wr_act;
			rd_act_q <= rd_act;
			phase <= phase + 2'h1;
			wr_seq <= seq_step(wr_seq, wr_act_q & ~wr_act, at_q2, at_q4); // RL9
			rd_seq <= seq_step(rd_seq, rd_act_q & ~rd_act, at_q2, at_q4); // RL15
		end
	end

	// slave port latches and flags
	always @(posedge clk_sys or posedge reset) begin
		if (reset) begin
			out_latch <= `PSP_RST_ZERO8;
			in_latch <= `PSP_RST_ZERO8;
			in_buffer_full <= 1'b0;
			out_buffer_full <= 1'b0;
			in_buffer_overflow <= 1'b0;
		end else begin
			if (fw_write && bus_idx == `PSP_IDX_DATA_PORT_LATCH) begin
				out_latch <= wdata; // RL6
			end
			// a transfer still in progress keeps loading, so the last byte wins
			if (wr_act) begin
				in_latch <= data_sync; // RL8 RL21
			end
			if (!slave_mode_select) begin
				in_buffer_full <= 1'b0; // RL17
				out_buffer_full <= 1'b0; // RL17
			end else begin
				// set wins over the clear by an internal read in the same cycle
				if (wr_fire) begin
					in_buffer_full <= 1'b1; // RL9
				end else if (fw_read && bus_idx == `PSP_IDX_DATA_PORT_LATCH) begin
					in_buffer_full <= 1'b0; // RL11
				end
				if (fw_write && bus_idx == `PSP_IDX_DATA_PORT_LATCH) begin
					out_buffer_full <= 1'b1; // RL16
				end else if (rd_start) begin
					out_buffer_full <= 1'b0; // RL14
				end
			end
			if (wr_start && in_buffer_full) begin
				in_buffer_overflow <= 1'b1; // RL12
			end else if (fw_write && bus_idx == `PSP_IDX_SLAVE_PORT_CONTROL) begin
				in_buffer_overflow <= wdata[`PSP_BIT_IN_OVERFLOW]; // RL17 RL18
			end
		end
	end

	// control, direction, irq and analog configuration registers
	always @(posedge clk_sys or posedge reset) begin
		if (reset) begin
			slave_mode_select <= 1'b0;
			strobe_dir <= `PSP_RST_STROBE_DIR; // RL19
			strobe_latch <= `PSP_RST_ZERO3;
			data_port_direction <= `PSP_RST_DIRECTION;
			irq_flags <= `PSP_RST_ZERO8;
			irq_enables <= `PSP_RST_ZERO8;
			analog_cfg <= `PSP_RST_ZERO8; // RL22
		end else begin
			if (fw_write) begin
				case (bus_idx)
					`PSP_IDX_SLAVE_PORT_CONTROL: begin
						slave_mode_select <= wdata[`PSP_BIT_MODE_SELECT]; // RL1
						strobe_dir <= wdata[`PSP_DIR_MSB:0]; // RL19
					end
					`PSP_IDX_STROBE_PORT_PINS: begin
						strobe_latch <= wdata[`PSP_DIR_MSB:0];
					end
					`PSP_IDX_DATA_PORT_DIRECTION: begin
						data_port_direction <= wdata;
					end
					`PSP_IDX_PERIPHERAL_IRQ_ENABLES: begin
						irq_enables <= wdata;
					end
					`PSP_IDX_ANALOG_PIN_CONFIG: begin
						analog_cfg <= wdata & `PSP_ANALOG_CFG_MASK;
					end
					default: begin
					end
				endcase
			end
			// the irq flag set by a finished transfer wins over a firmware write
			if (fw_write && bus_idx == `PSP_IDX_PERIPHERAL_IRQ_FLAGS) begin
				irq_flags <= wdata; // RL18
			end
			if (wr_fire || rd_fire) begin
				irq_flags[`PSP_BIT_IRQ] <= 1'b1; // RL10 RL15
			end
		end
	end

	// pin drivers and interrupt request, all from flip-flops
	always @(posedge clk_sys or posedge reset) begin
		if (reset) begin
			data_pins_out <= `PSP_RST_ZERO8;
			data_pins_oe <= `PSP_RST_ZERO8;
			strobe_pins_out <= `PSP_RST_ZERO3;
			strobe_pins_oe <= `PSP_RST_ZERO3;
			slave_port_irq <= 1'b0;
		end else begin
			data_pins_out <= out_latch; // RL13
			data_pins_oe <= next_data_oe; // RL7
			strobe_pins_out <= strobe_latch;
			// slave mode never drives the strobe pins, whatever the directions say
			strobe_pins_oe <= slave_mode_select ? `PSP_RST_ZERO3 : ~strobe_dir; // RL3 RL19
			slave_port_irq <= irq_flags[`PSP_BIT_IRQ] & irq_enables[`PSP_BIT_IRQ]; // RL18
		end
	end

endmodule

// ===== tb/psp_port_assertions.sv
// checker for the slave port: bus timing, pin drive, strobe direction
// assumes a bind onto psp_port with a single AHB-Lite master
`timescale 1ns/1ns
module psp_port_checker (
	// clock and reset
	input wire        clk_sys,
	input wire        reset,
	// bus
	input wire        hsel,
	input wire [31:0] haddr,
	input wire [1:0]  htrans,
	input wire        hwrite,
	input wire [31:0] hwdata,
	input wire        hready,
	input wire [31:0] hrdata,
	input wire        hreadyout,
	input wire        hresp,
	// pins
	input wire [7:0]  data_pins_out,
	input wire [7:0]  data_pins_oe,
	input wire [2:0]  strobe_pins_in,
	input wire [2:0]  strobe_pins_oe
);
	default clocking @(posedge clk_sys); endclocking
	default disable iff (reset);
	wire take = hsel & hready & htrans[1];
	wire sel_rd = ~strobe_pins_in[0] & ~strobe_pins_in[2];
	reg  ctl_dp;
	reg  dat_dp;
	reg  mode;
	// mode is shadowed from bus writes: the register itself is out of sight
	always @(posedge clk_sys or posedge reset)
		if (reset) begin
			ctl_dp <= 1'b0;
			dat_dp <= 1'b0;
			mode <= 1'b0;
		end else begin
			ctl_dp <= take & hwrite & (haddr[9:2] == 8'h89);
			dat_dp <= take & hwrite & (haddr[9:2] == 8'h08);
			if (ctl_dp)
				mode <= hwdata[4];
		end
	a_resp_okay: assert property (hresp == 1'b0)
		else $error("bus response not okay");
	a_read_wait: assert property (take && !hwrite |=> !hreadyout ##1 hreadyout)
		else $error("read data phase not one wait cycle");
	a_write_fast: assert property (take && hwrite |=> hreadyout)
		else $error("write data phase stalled");
	a_rdata_hold: assert property (hreadyout && $past(hreadyout) |-> $stable(hrdata))
		else $error("read data moved outside a read");
	a_dout_load: assert property (dat_dp |-> ##2 data_pins_out == $past(hwdata[7:0], 2))
		else $error("output latch not on data pins");
	a_strobe_in: assert property (mode && $past(mode) |-> strobe_pins_oe == 3'h0)
		else $error("strobe pin driven in slave mode");
	a_oe_sync: assert property (mode && $rose(sel_rd) |->
		(data_pins_oe == 8'h00) [*2] ##[1:2] data_pins_oe == 8'hFF)
		else $error("read drive not after two sync stages");
	a_oe_cause: assert property (mode && $past(mode) && data_pins_oe != 8'h00 |-> $past(sel_rd, 1)
		|| $past(sel_rd, 2) || $past(sel_rd, 3) || $past(sel_rd, 4))
		else $error("data pins driven without a selected read");
endmodule

// ===== tb/psp_ext_cpu.sv
// external 8-bit cpu driving the slave port strobes and data bus
// assumes the bench resolves the shared bus from the port's data pin enables alone
`timescale 1ns/1ns
module psp_ext_cpu (
	// clock
	input  wire        clk_sys,
	// resolved data bus
	input  wire  [7:0] bus,
	// strobes: bit 0 read, bit 1 write, bit 2 select, low active
	output logic [2:0] strb,
	output logic [7:0] dat
);
	logic       drv;
	logic [7:0] held;
	logic [7:0] idle;
	// a released bus flips each cycle so a stale byte never looks valid
	assign dat = drv ? held : idle;
	initial begin
		strb = 3'h7;
		drv = 1'b0;
		held = 8'h00;
		idle = 8'h55;
	end
	always @(posedge clk_sys)
		idle <= ~idle;
	task put(input logic [7:0] b);
		@(posedge clk_sys);
		drv <= 1'b1;
		held <= b;
		strb <= 3'h1;
		repeat (4) @(posedge clk_sys);
		strb <= 3'h7;
		repeat (2) @(posedge clk_sys);
		drv <= 1'b0;
		repeat (8) @(posedge clk_sys);
	endtask
	task get(output logic [7:0] b);
		@(posedge clk_sys);
		strb <= 3'h2;
		repeat (5) @(posedge clk_sys);
		b = bus;
		strb <= 3'h7;
		repeat (8) @(posedge clk_sys);
	endtask
endmodule

// ===== tb/psp_port_tb_top.sv
// slave port bench: AHB-Lite register tasks against an external cpu model
// assumes psp_port, its checker and the cpu model are compiled first
`timescale 1ns/1ns
module psp_port_tb_top;
	localparam [31:0] ad_dat = 32'h20;
	localparam [31:0] ad_pin = 32'h24;
	localparam [31:0] ad_irf = 32'h30;
	localparam [31:0] ad_ctl = 32'h224;
	localparam [31:0] ad_dir = 32'h220;
	localparam [31:0] ad_ire = 32'h230;
	logic        clk_sys;
	logic        reset;
	logic        hsel;
	logic [2:0]  hsize;
	logic [31:0] haddr;
	logic [1:0]  htrans;
	logic        hwrite;
	logic [31:0] hwdata;
	wire  [31:0] hrdata;
	wire         hrdy;
	wire  [7:0]  dout, doe, xdat;
	wire  [2:0]  sout, soe, xstb;
	wire         irq;
	int          miscompares;
	int          num_checks;
	int          cycles;
	logic [7:0]  got;
	wire  [7:0]  din = (doe & dout) | (~doe & xdat);
	wire  [2:0]  sin = (soe & sout) | (~soe & xstb);
	psp_port DUT (.clk_sys(clk_sys), .reset(reset), .hsel(hsel), .haddr(haddr),
		.htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hrdy),
		.hrdata(hrdata), .hreadyout(hrdy), .hresp(), .data_pins_in(din),
		.data_pins_out(dout), .data_pins_oe(doe), .strobe_pins_in(sin),
		.strobe_pins_out(sout), .strobe_pins_oe(soe), .slave_port_irq(irq));
	psp_ext_cpu ext (.clk_sys(clk_sys), .bus(din), .strb(xstb), .dat(xdat));
	initial begin
		clk_sys = 1'b0;
		forever #10 clk_sys = ~clk_sys;
	end
	task test_done;
		$display("checks %0d mismatches %0d", num_checks, miscompares);
		if (miscompares == 0 && num_checks > 0)
			$display("Result: passed");
		else
			$display("Result: failed");
		$finish;
	endtask
	always @(posedge clk_sys) begin
		cycles = cycles + 1;
		if (cycles == 20000) begin
			miscompares++;
			test_done;
		end
	end
	task chk(input string n, input logic [31:0] s, e);
		num_checks++;
		if (s !== e) begin
			miscompares++;
			$display("[FAIL] %s exp %h seen %h", n, e, s);
		end
	endtask
	task bus(input logic w, input logic [31:0] a, d, output logic [31:0] q);
		@(posedge clk_sys);
		hsel <= 1'b1;
		haddr <= a;
		hwrite <= w;
		hsize <= 3'h2;
		htrans <= 2'h2;
		do @(posedge clk_sys); while (hrdy !== 1'b1);
		hsel <= 1'b0;
		htrans <= 2'h0;
		hwdata <= d;
		do @(posedge clk_sys); while (hrdy !== 1'b1);
		q = hrdata;
	endtask
	task rc(input logic [31:0] a, input logic [7:0] e, input string n);
		logic [31:0] q;
		bus(1'b0, a, 32'h0, q);
		chk(n, q, {24'h0, e});
	endtask
	task wr(input logic [31:0] a, input logic [7:0] d);
		logic [31:0] q;
		bus(1'b1, a, {24'h0, d}, q);
	endtask
	initial begin
		reset = 1'b1;
		hsel = 1'b0;
		hsize = 3'h0;
		haddr = 32'h0;
		htrans = 2'h0;
		hwrite = 1'b0;
		hwdata = 32'h0;
		repeat (12) @(posedge clk_sys);
		reset <= 1'b0;
		rc(ad_ctl, 8'h07, "ctl");
		rc(ad_irf, 8'h00, "flags");
		rc(ad_pin, 8'h00, "analog pins");
		rc(32'h3FC, 8'h00, "unmapped");
		wr(ad_dat, 8'h3C);
		wr(ad_dir, 8'h00);
		rc(ad_dir, 8'h00, "direction");
		rc(ad_dat, 8'h3C, "pin loop");
		wr(ad_ctl, 8'h00);
		wr(ad_pin, 8'h05);
		repeat (2) @(posedge clk_sys);
		chk("strobe oe", {29'h0, soe}, 32'h7);
		chk("strobe out", {29'h0, sout}, 32'h5);
		wr(ad_ctl, 8'hE7);
		rc(ad_ctl, 8'h27, "ctl bits");
		wr(32'h27C, 8'h07);
		rc(ad_pin, 8'h07, "digital pins");
		wr(ad_ire, 8'h80);
		wr(ad_ctl, 8'h17);
		ext.put(8'hA5);
		rc(ad_ctl, 8'h97, "in full");
		rc(ad_irf, 8'h80, "wr flag");
		chk("irq on", {31'h0, irq}, 32'h1);
		rc(ad_dat, 8'hA5, "in latch");
		rc(ad_ctl, 8'h17, "in read");
		wr(ad_irf, 8'h00);
		ext.put(8'h3C);
		ext.put(8'hC3);
		rc(ad_ctl, 8'hB7, "overflow");
		rc(ad_dat, 8'hC3, "overwrite");
		wr(ad_ctl, 8'h17);
		wr(ad_ire, 8'h00);
		wr(ad_irf, 8'h00);
		wr(ad_dat, 8'h5A);
		rc(ad_ctl, 8'h57, "out full");
		ext.get(got);
		chk("ext read", {24'h0, got}, 32'h5A);
		rc(ad_ctl, 8'h17, "out read");
		rc(ad_irf, 8'h80, "rd flag");
		chk("irq off", {31'h0, irq}, 32'h0);
		ext.put(8'h11);
		ext.put(8'h22);
		wr(ad_ctl, 8'h27);
		ext.put(8'h99);
		rc(ad_ctl, 8'h27, "mode off");
		test_done;
	end
endmodule
bind psp_port psp_port_checker u_chk (.clk_sys, .reset, .hsel, .haddr, .htrans, .hwrite,
	.hwdata, .hready, .hrdata, .hreadyout, .hresp, .data_pins_out, .data_pins_oe,
	.strobe_pins_in, .strobe_pins_oe);
